// >>> dv/addr_phase_monitor.sv
// Checker for the address-phase block: master drive window, snoop sampling, parity error pulse.
// Assumes only the top module's ports, one clock, bound from the bench.
`default_nettype none
module addr_phase_monitor (
   input wire logic                        i_clk_sys,
   input wire logic                        i_rst_b,
   input wire logic                        i_addr_parity_check_enable,
   input wire logic                        i_mst_start,
   input wire logic                        i_mst_end,
   input wire logic                        o_machine_check,
   input wire addr_phase_pkg::snoop_info_t o_snoop,
   input wire logic                        i_transfer_start_strobe_b,
   input wire logic                        i_global_snoop_qualifier_b,
   input wire addr_phase_pkg::addr_bus_t   i_bus,
   input wire addr_phase_pkg::addr_bus_t   o_bus,
   input wire logic                        o_bus_oe,
   input wire logic                        o_addr_parity_error_out_b,
   input wire logic                        o_addr_parity_error_out_oe
);
   logic snoop, bad_en;
   function automatic logic odd4(input addr_phase_pkg::addr_bus_t b);
      return &{^{b.addr[31:24], b.par[0]}, ^{b.addr[23:16], b.par[1]}, ^{b.addr[15:8], b.par[2]}, ^{b.addr[7:0], b.par[3]}};
   endfunction : odd4
   // Own phase owns the bus, so strobes then are not foreign
   assign snoop  = i_rst_b && !i_transfer_start_strobe_b && !o_bus_oe && !i_mst_start;
   assign bad_en = snoop && i_addr_parity_check_enable && !odd4(i_bus);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_bad_glb; bad_en && !i_global_snoop_qualifier_b; endsequence
   sequence s_perr_pulse; !o_addr_parity_error_out_oe ##1 o_addr_parity_error_out_oe ##1 !o_addr_parity_error_out_oe; endsequence
   property p_perr_win; s_bad_glb |=> s_perr_pulse; endproperty
   a_perr_win: assert property (p_perr_win) else $error("error pulse window wrong");
   property p_perr_quiet; snoop && !(bad_en && !i_global_snoop_qualifier_b) |-> ##2 !o_addr_parity_error_out_oe; endproperty
   a_perr_quiet: assert property (p_perr_quiet) else $error("error output without cause");
   property p_perr_low; o_addr_parity_error_out_oe |-> !o_addr_parity_error_out_b; endproperty
   a_perr_low: assert property (p_perr_low) else $error("error line not driven low");
   property p_mchk; o_machine_check == $past(bad_en); endproperty
   a_mchk: assert property (p_mchk) else $error("machine check mismatch");
   property p_snoop; snoop |=> o_snoop.valid && o_snoop.addr == $past(i_bus.addr); endproperty
   a_snoop: assert property (p_snoop) else $error("snoop sample wrong");
   property p_own; !i_transfer_start_strobe_b && o_bus_oe |=> !o_snoop.valid && !o_machine_check; endproperty
   a_own: assert property (p_own) else $error("own phase was checked");
   property p_oe_rise; i_mst_start && !o_bus_oe |=> o_bus_oe; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("bus not driven");
   property p_oe_fall; o_bus_oe && i_mst_end && !i_mst_start |=> !o_bus_oe; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("bus not released");
   property p_par; o_bus_oe |-> odd4(o_bus); endproperty
   a_par: assert property (p_par) else $error("driven parity not odd");
   property p_code; o_bus_oe |-> o_bus.code inside {5'h0a, 5'h0e, 5'h1a, 5'h1e, 5'h02, 5'h06, 5'h12, 5'h1c, 5'h14, 5'h0c}; endproperty
   a_code: assert property (p_code) else $error("illegal type code driven");
endmodule : addr_phase_monitor
`default_nettype wire

// >>> dv/bus_address_parity_ttype_bench.sv
// Self-checking bench: master codes table, snoop cases table, reset and own-phase case.
// Assumes the partner model drives the far side of the bus.
`default_nettype none
module bus_address_parity_ttype_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed { logic [3:0] op; logic [4:0] code; } row_t;
   typedef struct packed { logic [3:0] flip; logic glb, en, mchk, perr; } snp_t;
   row_t rows [10] = '{'{4'h0, 5'h0a}, '{4'h1, 5'h0e}, '{4'h2, 5'h1a}, '{4'h3, 5'h1e}, '{4'h4, 5'h02},
                       '{4'h5, 5'h06}, '{4'h6, 5'h12}, '{4'h7, 5'h1c}, '{4'h8, 5'h14}, '{4'h9, 5'h0c}};
   snp_t sn [4] = '{'{4'h0, 1'b1, 1'b1, 1'b0, 1'b0}, '{4'h2, 1'b1, 1'b1, 1'b1, 1'b1},
                    '{4'h8, 1'b0, 1'b1, 1'b1, 1'b0}, '{4'h1, 1'b1, 1'b0, 1'b0, 1'b0}};
   logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_addr_parity_check_enable = 1'b1, i_mst_start = 1'b0, i_mst_end = 1'b0;
   logic o_machine_check, i_transfer_start_strobe_b, i_global_snoop_qualifier_b, o_bus_oe;
   logic o_addr_parity_error_out_b, o_addr_parity_error_out_oe, perr_line;
   logic [31:0] i_mst_addr = 32'h0, a;
   addr_phase_pkg::master_op_t  i_mst_op = addr_phase_pkg::OP_READ_CI;
   addr_phase_pkg::snoop_info_t o_snoop;
   addr_phase_pkg::addr_bus_t   i_bus, o_bus;
   int mismatches = 0, check_count = 0;
   always #20 i_clk_sys = ~i_clk_sys;
   bus_address_parity_ttype bus_address_parity_ttype_inst (.i_clk_sys, .i_rst_b, .i_addr_parity_check_enable,
      .i_mst_start, .i_mst_end, .i_mst_op, .i_mst_addr, .o_machine_check, .o_snoop, .i_transfer_start_strobe_b,
      .i_global_snoop_qualifier_b, .i_bus, .o_bus, .o_bus_oe, .o_addr_parity_error_out_b, .o_addr_parity_error_out_oe);
   other_master other_master_inst (.i_clk_sys, .i_dut_bus(o_bus), .i_dut_oe(o_bus_oe),
      .i_perr_oe(o_addr_parity_error_out_oe), .o_strobe_b(i_transfer_start_strobe_b),
      .o_global_b(i_global_snoop_qualifier_b), .o_wire(i_bus), .o_perr_line(perr_line));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude;
      $display("comparisons=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   initial begin
      #200000 mismatches++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge i_clk_sys);
      #1 i_rst_b = 1'b1;
      check({o_bus_oe, o_addr_parity_error_out_oe, o_addr_parity_error_out_b, o_machine_check, o_snoop.valid, o_bus},
            {5'b00100, 41'h0});
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         a = 32'h8421_3c5a ^ {4{8'(i * 37)}};
         i_mst_op = addr_phase_pkg::master_op_t'(rows[i].op);
         i_mst_addr = a;
         i_mst_start = 1'b1;
         @(posedge i_clk_sys);
         #1 i_mst_start = 1'b0;
         i_mst_end = 1'b1;
         check({o_bus_oe, o_bus}, {1'b1, a, other_master_inst.odd_par(a), rows[i].code});
         @(posedge i_clk_sys);
         #1 i_mst_end = 1'b0;
         check(o_bus_oe, 1'b0);
         $display("test master row %0d done", i);
      end
      for (int i = 0; i < 4; i++) begin
         a = 32'h5a3c_0f10 + 32'(i);
         i_addr_parity_check_enable = sn[i].en;
         // Growing lag gives prompt and slow far-side answers
         other_master_inst.snoop(a, sn[i].flip, sn[i].glb, i);
         check({o_snoop.valid, o_snoop.addr, o_machine_check}, {1'b1, a, sn[i].mchk});
         @(posedge i_clk_sys);
         #1 check({o_addr_parity_error_out_oe, perr_line}, {sn[i].perr, ~sn[i].perr});
         @(posedge i_clk_sys);
         #1 check({o_addr_parity_error_out_oe, perr_line}, 2'b01);
         $display("test snoop case %0d done", i);
      end
      i_addr_parity_check_enable = 1'b1;
      i_mst_start = 1'b1;
      @(posedge i_clk_sys);
      #1 i_mst_start = 1'b0;
      other_master_inst.snoop(32'h0000_0001, 4'hf, 1'b1, 0);
      check({o_snoop.valid, o_machine_check}, 2'b00);
      @(posedge i_clk_sys);
      #1 check(o_addr_parity_error_out_oe, 1'b0);
      $display("test own phase done");
      conclude();
   end
endmodule : bus_address_parity_ttype_bench
bind bus_address_parity_ttype addr_phase_monitor addr_phase_monitor_inst (.i_clk_sys, .i_rst_b,
   .i_addr_parity_check_enable, .i_mst_start, .i_mst_end, .o_machine_check, .o_snoop, .i_transfer_start_strobe_b,
   .i_global_snoop_qualifier_b, .i_bus, .o_bus, .o_bus_oe, .o_addr_parity_error_out_b, .o_addr_parity_error_out_oe);
`default_nettype wire

// >>> dv/other_master.sv
// Model of another bus master: start strobe, snoop address, parity, type code.
// Assumes the bench calls snoop just after a rising edge; error line has a pull-up.
`default_nettype none
module other_master (
   input  wire logic                      i_clk_sys,
   input  wire addr_phase_pkg::addr_bus_t i_dut_bus,
   input  wire logic                      i_dut_oe,
   input  wire logic                      i_perr_oe,
   output logic                           o_strobe_b,
   output logic                           o_global_b,
   output addr_phase_pkg::addr_bus_t      o_wire,
   output logic                           o_perr_line
);
   timeunit 1ns;
   timeprecision 1ns;
   addr_phase_pkg::addr_bus_t drv = '0;
   function automatic logic [3:0] odd_par(input logic [31:0] a);
      return {~^a[7:0], ~^a[15:8], ~^a[23:16], ~^a[31:24]};
   endfunction : odd_par
   assign o_wire     = i_dut_oe ? i_dut_bus : drv;
   assign o_perr_line = i_perr_oe ? 1'b0 : 1'b1;
   initial begin
      o_strobe_b = 1'b1;
      o_global_b = 1'b1;
   end
   task automatic snoop(input logic [31:0] a, input logic [3:0] flip, input logic glb, input int lag);
      repeat (lag) @(posedge i_clk_sys);
      #1 o_strobe_b = 1'b0;
      o_global_b = ~glb;
      drv = {a, odd_par(a) ^ flip, 5'h0e};
      @(posedge i_clk_sys);
      #1 o_strobe_b = 1'b1;
      o_global_b = 1'b1;
      // Released lines must not keep the sampled value
      drv = ~drv;
   endtask : snoop
endmodule : other_master
`default_nettype wire

// >>> pkg/addr_phase_pkg.sv
// Package for the system bus address-phase block: transfer-type codes,
// bus widths and the carrier structs shared by the design files.
// Assumes a single 25 MHz bus clock and synchronous active-low reset.
`default_nettype none

package addr_phase_pkg;

   localparam int unsigned ADDR_W   = 32;
   localparam int unsigned NBYTES   = 4;
   localparam int unsigned CODE_W   = 5;
   localparam int unsigned CLK_MHZ  = 25;

   // Parity error drive window, in bus cycles after the start strobe
   localparam logic [1:0] PERR_ASSERT_CYC  = 2'h2;
   localparam logic [1:0] PERR_RELEASE_CYC = 2'h3;

   // Operation requested by the core for a master address phase
   typedef enum logic [3:0] {
      OP_READ_CI       = 4'b0000,
      OP_READ_RWITM    = 4'b0001,
      OP_READ_ATOMIC   = 4'b0010,
      OP_READ_ATOM_BST = 4'b0011,
      OP_WRITE_CI      = 4'b0100,
      OP_WRITE_CASTOUT = 4'b0101,
      OP_WRITE_COND    = 4'b0110,
      OP_EXT_READ      = 4'b0111,
      OP_EXT_WRITE     = 4'b1000,
      OP_KILL_BLOCK    = 4'b1001
   } master_op_t;

   localparam logic [4:0] CODE_READ_CI       = 5'h0a;
   localparam logic [4:0] CODE_READ_RWITM    = 5'h0e;
   localparam logic [4:0] CODE_READ_ATOMIC   = 5'h1a;
   localparam logic [4:0] CODE_READ_ATOM_BST = 5'h1e;
   localparam logic [4:0] CODE_WRITE_CI      = 5'h02;
   localparam logic [4:0] CODE_WRITE_CASTOUT = 5'h06;
   localparam logic [4:0] CODE_WRITE_COND    = 5'h12;
   localparam logic [4:0] CODE_EXT_READ      = 5'h1c;
   localparam logic [4:0] CODE_EXT_WRITE     = 5'h14;
   localparam logic [4:0] CODE_KILL_BLOCK    = 5'h0c;

   // Snooped operation classes
   typedef enum logic [2:0] {
      SN_NONE     = 3'b000,
      SN_KILL     = 3'b001,
      SN_WRITE    = 3'b010,
      SN_READ     = 3'b011,
      SN_RWITM    = 3'b100,
      SN_ADDRONLY = 3'b101,
      SN_RESERVED = 3'b110
   } snoop_class_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [NBYTES-1:0] par;
      logic [CODE_W-1:0] code;
   } addr_bus_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      snoop_class_t      kind;
   } snoop_info_t;

endpackage : addr_phase_pkg

`default_nettype wire

// >>> src/addr_parity_gen.sv
// Odd byte-parity generator for the 32-bit address (one bit per byte).
// Pure combinational; the caller registers the result.
`default_nettype none

module addr_parity_gen (
   input  wire logic [addr_phase_pkg::ADDR_W-1:0] i_addr,
   output logic      [addr_phase_pkg::NBYTES-1:0] o_par
);

   // Bit 0 covers address bits 0-7 in big-endian order, i.e. the top byte
   for (genvar g = 0; g < addr_phase_pkg::NBYTES; g++) begin : g_byte
      assign o_par[g] = ~^i_addr[addr_phase_pkg::ADDR_W-1-8*g -: 8];
   end

endmodule : addr_parity_gen

`default_nettype wire

// >>> src/bus_address_parity_ttype.sv
// Address-phase logic of the shared system bus: master type code and
// address parity drive, snoop sampling, parity check and error output.
// Assumes all bus pins synchronous to i_clk_sys; the board resolves
// two-way pins from the enables and pulls the open-drain error line up.
//
// Operation
// - Odd parity bit per address byte
// - Parity drive/float with address lines
// - Even snooped parity raises machine check
// - Error output on bad global parity
// - No error output while checking disabled
// - Error asserts cycle two, floats three
// - Type code five bits, bidirectional
// - Type code drive/float with address
// - Decode snooped type on start cycle
// - Read operations use listed read codes
// - Write operations use listed write codes
// - External control ops use their codes
// - Block zero and unknown ops issue kill; others never
`default_nettype none

module bus_address_parity_ttype (
   input  wire logic                                i_clk_sys,
   input  wire logic                                i_rst_b,
   // Core side
   input  wire logic                                i_addr_parity_check_enable,
   input  wire logic                                i_mst_start,
   input  wire logic                                i_mst_end,
   input  wire addr_phase_pkg::master_op_t          i_mst_op,
   input  wire logic [addr_phase_pkg::ADDR_W-1:0]   i_mst_addr,
   output logic                                     o_machine_check,
   output addr_phase_pkg::snoop_info_t              o_snoop,
   // Bus pins
   input  wire logic                                i_transfer_start_strobe_b,
   input  wire logic                                i_global_snoop_qualifier_b,
   input  wire addr_phase_pkg::addr_bus_t           i_bus,
   output addr_phase_pkg::addr_bus_t                o_bus,
   output logic                                     o_bus_oe,
   output logic                                     o_addr_parity_error_out_b,
   output logic                                     o_addr_parity_error_out_oe
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      addr_phase_pkg::addr_bus_t   bus;
      logic                        bus_oe;
      logic                        own_phase;
      logic [1:0]                  perr_cnt;
      logic                        perr_seen;
      logic                        perr_oe;
      logic                        perr_b;
      logic                        mchk;
      addr_phase_pkg::snoop_info_t snoop;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [addr_phase_pkg::NBYTES-1:0] mst_par;
   logic [addr_phase_pkg::NBYTES-1:0] snp_par;
   logic                              snoop_cycle;
   logic                              par_bad;

   addr_parity_gen u_mst_par (
      .i_addr (i_mst_addr),
      .o_par  (mst_par)
   );

   addr_parity_gen u_snp_par (
      .i_addr (i_bus.addr),
      .o_par  (snp_par)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoding

   function automatic logic [4:0] op_to_code(input addr_phase_pkg::master_op_t op);
      case (op)
         addr_phase_pkg::OP_READ_CI:       op_to_code = addr_phase_pkg::CODE_READ_CI;
         addr_phase_pkg::OP_READ_RWITM:    op_to_code = addr_phase_pkg::CODE_READ_RWITM;
         addr_phase_pkg::OP_READ_ATOMIC:   op_to_code = addr_phase_pkg::CODE_READ_ATOMIC;
         addr_phase_pkg::OP_READ_ATOM_BST: op_to_code = addr_phase_pkg::CODE_READ_ATOM_BST;
         addr_phase_pkg::OP_WRITE_CI:      op_to_code = addr_phase_pkg::CODE_WRITE_CI;
         addr_phase_pkg::OP_WRITE_CASTOUT: op_to_code = addr_phase_pkg::CODE_WRITE_CASTOUT;
         addr_phase_pkg::OP_WRITE_COND:    op_to_code = addr_phase_pkg::CODE_WRITE_COND;
         addr_phase_pkg::OP_EXT_READ:      op_to_code = addr_phase_pkg::CODE_EXT_READ;
         addr_phase_pkg::OP_EXT_WRITE:     op_to_code = addr_phase_pkg::CODE_EXT_WRITE;
         // Unknown ops fall back to kill; no forbidden code can leave
         default:                          op_to_code = addr_phase_pkg::CODE_KILL_BLOCK;
      endcase
   endfunction : op_to_code

   // Only the upper four type bits are trusted as snoop inputs
   function automatic addr_phase_pkg::snoop_class_t classify(input logic [4:0] code);
      logic [3:0] hi;
      hi = code[4:1];
      if (hi == addr_phase_pkg::CODE_KILL_BLOCK[4:1]) begin
         classify = addr_phase_pkg::SN_KILL;
      end else if (hi == 4'h1 || hi == 4'h3 || hi == 4'h9) begin
         classify = addr_phase_pkg::SN_WRITE;
      end else if (hi == 4'h5 || hi == 4'hd) begin
         classify = addr_phase_pkg::SN_READ;
      end else if (hi == 4'h7 || hi == 4'hf) begin
         classify = addr_phase_pkg::SN_RWITM;
      end else if (hi[0] == 1'b0) begin
         classify = addr_phase_pkg::SN_ADDRONLY;
      end else begin
         classify = addr_phase_pkg::SN_RESERVED;
      end
   endfunction : classify

   ////////////////////////////////////////////////////////////////////////
   // Next state

   // Our own strobe coincides with i_mst_start or falls in own_phase; foreign strobe otherwise
   assign snoop_cycle = ~i_transfer_start_strobe_b & ~s_q.own_phase & ~i_mst_start;
   assign par_bad     = (snp_par != i_bus.par);

   always_comb begin
      s_d = s_q;
      s_d.mchk        = 1'b0;
      s_d.snoop.valid = 1'b0;

      // Master drive: address, parity and type share one enable
      if (i_mst_start) begin
         s_d.bus.addr  = i_mst_addr;
         s_d.bus.par   = mst_par;
         s_d.bus.code  = op_to_code(i_mst_op);
         s_d.bus_oe    = 1'b1;
         s_d.own_phase = 1'b1;
      end else if (i_mst_end) begin
         s_d.bus_oe    = 1'b0;
         s_d.own_phase = 1'b0;
      end

      // Sample snoop inputs on the foreign start cycle only
      if (snoop_cycle) begin
         s_d.snoop.valid = 1'b1;
         s_d.snoop.addr  = i_bus.addr;
         s_d.snoop.kind  = classify(i_bus.code);
         s_d.perr_cnt    = 2'h1;
         s_d.perr_seen   = par_bad & ~i_global_snoop_qualifier_b & i_addr_parity_check_enable;
         s_d.mchk        = par_bad & i_addr_parity_check_enable;
      end else if (s_q.perr_cnt != 2'h0) begin
         s_d.perr_cnt = (s_q.perr_cnt == addr_phase_pkg::PERR_RELEASE_CYC) ? 2'h0 : s_q.perr_cnt + 2'h1;
      end

      // Drive low in cycle two when an error was seen, float in cycle three
      s_d.perr_oe = (s_d.perr_cnt == addr_phase_pkg::PERR_ASSERT_CYC)
                    & s_d.perr_seen & i_addr_parity_check_enable;
      // Pin level in its own flop so the output leaves a register
      s_d.perr_b  = ~s_d.perr_oe;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         s_q        <= '0;
         s_q.perr_b <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_bus                      = s_q.bus;
   assign o_bus_oe                   = s_q.bus_oe;
   assign o_addr_parity_error_out_b  = s_q.perr_b;
   assign o_addr_parity_error_out_oe = s_q.perr_oe;
   assign o_machine_check            = s_q.mchk;
   assign o_snoop                    = s_q.snoop;

endmodule : bus_address_parity_ttype

`default_nettype wire
